/* segmented_adc_sequencer.sv */
// What this block does
// [R01] A 6-bit stored offset code is driven to the analog path as the coarse offset shift.
// [R02] The offset shift per step is 12.5, 7.6, 5.2 or 0.83 percent of span by gain row.
// [R03] Fine offset is not removed here; raw results go to the conditioning processor.
// [R04] Total resolution is selectable as 13 or 14 bits.
// [R05] Operation is selectable as single segment or two segment.
// [R06] The coarse segment integrates over all the time the measurement cycle leaves.
// [R07] In two segment mode the coarse residual is then converted by the fine converter.
// [R08] In single segment mode the fine step is skipped and the split code is ignored.
// [R09] The split code sets coarse/fine widths, 12/2 to 9/5 at 14 bits, 11/2 to 8/5 at 13.
// [R10] Measurement cycle lengths follow the printed times for each mode.
// [R11] The result is coarse bits above fine bits, valid only after both segments end.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "seg_adc_defs.svh"
module segmented_adc_sequencer
  import seg_adc_pkg::*;
#(
  parameter int unsigned PER_CYC [10] = '{
    `SEG_T14_00_US * `SEG_CLK_MHZ, `SEG_T14_01_US * `SEG_CLK_MHZ,
    `SEG_T14_10_US * `SEG_CLK_MHZ, `SEG_T14_11_US * `SEG_CLK_MHZ,
    `SEG_T13_00_US * `SEG_CLK_MHZ, `SEG_T13_01_US * `SEG_CLK_MHZ,
    `SEG_T13_10_US * `SEG_CLK_MHZ, `SEG_T13_11_US * `SEG_CLK_MHZ,
    `SEG_T14_ONE_US * `SEG_CLK_MHZ, `SEG_T13_ONE_US * `SEG_CLK_MHZ}
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [5:0]       coarseOffsetShift,
  output logic             coarseIntegrate,
  input  wire logic [13:0] coarseCode,
  output logic [4:0]       fineDac,
  input  wire logic        fineCompare,
  output logic [13:0]      result,
  output logic             resultValid
);

  logic [31:0] ctrl_q;
  cfg_s        cfg;
  cfg_s        cur_q;
  layout_s     lay;
  layout_s     curLay_q;
  phase_e      state_q;
  count_t      perCnt_q;
  count_t      coarseCnt_q;
  logic [13:0] coarseVal_q;
  logic        validFlag_q;
  logic        sarStart;
  logic        sarDone;
  logic        cycleStart;
  logic [15:0] stepSize;
  logic [21:0] shiftTotal;
  logic [13:0] coarseMask;
  logic [13:0] fineMask;
  logic [7:0]  awAddr_q;
  logic        awHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wHeld_q;
  logic        doWrite;
  logic [31:0] rdNext;
  logic        rdOk;

  assign cfg = cfg_s'({ctrl_q[`SEG_CTRL_OFFSET +: 6], ctrl_q[`SEG_CTRL_GAIN +: 4],
                       ctrl_q[`SEG_CTRL_SPLIT +: 2], ctrl_q[`SEG_CTRL_TWO],
                       ctrl_q[`SEG_CTRL_RES14], ctrl_q[`SEG_CTRL_RUN]});

  // segment layout and cycle time from the live settings
  seg_split_decode #(
    .PER_CYC (PER_CYC)
  ) u_decode (
    .res14   (cfg.res14),
    .twoStep (cfg.twoStep),
    .split   (cfg.split),
    .layout  (lay)
  );

  // fine converter working on the coarse residual
  seg_fine_sar #(
    .W (5)
  ) u_fine (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (sarStart),
    .nBits   (curLay_q.fineBits),
    .cmpHigh (fineCompare),
    .dacCode (fineDac),
    .done    (sarDone)
  );

  // per-step offset by gain row
  always_comb
  begin
    case (cur_q.gainRow)
      4'd2, 4'd4, 4'd6, 4'd8, 4'd11: stepSize = `SEG_STEP_B; // R02
      4'd9, 4'd12:                   stepSize = `SEG_STEP_C; // R02
      4'd13:                         stepSize = `SEG_STEP_D; // R02
      default:                       stepSize = `SEG_STEP_A; // R02
    endcase
    shiftTotal = 22'(stepSize) * 22'(cur_q.offsetCode);
  end

  // masks for the selected segment widths
  assign coarseMask = 14'((15'h1 << curLay_q.coarseBits) - 15'h1);
  assign fineMask = 14'((15'h1 << curLay_q.fineBits) - 15'h1);

  // a new measurement starts from idle or when the previous cycle time expires
  assign cycleStart = cfg.run && (state_q == PH_IDLE ||
                      (state_q == PH_WAIT && perCnt_q == '0));
  assign sarStart = state_q == PH_COARSE && coarseCnt_q == '0 && cur_q.twoStep;
  assign coarseIntegrate = state_q == PH_COARSE; // R06

  // conversion phase sequencing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= PH_IDLE;
    else
    begin
      case (state_q)
        PH_IDLE:
          if (cycleStart)
            state_q <= PH_COARSE;
        PH_COARSE:
          if (coarseCnt_q == '0)
            state_q <= cur_q.twoStep ? PH_FINE : PH_WAIT; // R07 R08
        PH_FINE:
          if (sarDone)
            state_q <= PH_WAIT; // R11
        PH_WAIT:
          if (perCnt_q == '0)
            state_q <= cfg.run ? PH_COARSE : PH_IDLE; // R10
        default:
          state_q <= PH_IDLE;
      endcase
    end
  end

  // settings captured for the whole measurement
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cur_q <= '0;
      curLay_q <= '0;
    end
    else if (cycleStart)
    begin
      cur_q <= cfg; // R04 R05
      curLay_q <= lay; // R09
    end
  end

  // offset code only changes between measurements
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      coarseOffsetShift <= '0;
    else if (cycleStart)
      coarseOffsetShift <= cfg.offsetCode; // R01
  end

  // cycle time counter and coarse window, which lasts the period minus fineBits minus 3 cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      perCnt_q <= '0;
      coarseCnt_q <= '0;
    end
    else if (cycleStart)
    begin
      perCnt_q <= lay.period - 20'h1; // R10
      coarseCnt_q <= lay.period - 20'(lay.fineBits) - 20'h4; // R06
    end
    else
    begin
      if (perCnt_q != '0)
        perCnt_q <= perCnt_q - 20'h1;
      if (state_q == PH_COARSE && coarseCnt_q != '0)
        coarseCnt_q <= coarseCnt_q - 20'h1;
    end
  end

  // coarse code latched at the end of integration
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      coarseVal_q <= '0;
    else if (state_q == PH_COARSE && coarseCnt_q == '0)
      coarseVal_q <= coarseCode & coarseMask;
  end

  // result assembly: coarse above fine, raw for the conditioning processor
  always_ff @(posedge sys_clk)
  begin
    resultValid <= 1'b0;
    if (rst)
      result <= '0;
    else if (state_q == PH_COARSE && coarseCnt_q == '0 && !cur_q.twoStep)
    begin
      result <= coarseCode & coarseMask; // R08 R03
      resultValid <= 1'b1;
    end
    else if (state_q == PH_FINE && sarDone)
    begin
      result <= 14'(coarseVal_q << curLay_q.fineBits) | (14'(fineDac) & fineMask); // R11
      resultValid <= 1'b1;
    end
  end

  // write channel capture, either order
  assign awready = !awHeld_q && !bvalid;
  assign wready = !wHeld_q && !bvalid;
  assign doWrite = awHeld_q && wHeld_q && !bvalid;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_q == `SEG_OFS_CTRL || awAddr_q == `SEG_OFS_STATUS) ? 2'b00 : 2'b10;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // control register with byte enables
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl_q <= `SEG_CTRL_RST;
    else if (doWrite && awAddr_q == `SEG_OFS_CTRL)
    begin
      for (int i = 0; i < 4; i++)
        if (wStrb_q[i])
          ctrl_q[i*8 +: 8] <= wData_q[i*8 +: 8];
    end
  end

  // sticky result flag, a new result wins over a clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      validFlag_q <= 1'b0;
    else if (resultValid)
      validFlag_q <= 1'b1;
    else if (doWrite && awAddr_q == `SEG_OFS_STATUS && wStrb_q[0] && wData_q[`SEG_STAT_VALID])
      validFlag_q <= 1'b0;
  end

  // read data select
  always_comb
  begin
    rdNext = '0;
    rdOk = 1'b1;
    case (araddr)
      `SEG_OFS_CTRL:   rdNext = ctrl_q;
      `SEG_OFS_STATUS:
      begin
        rdNext[`SEG_STAT_BUSY] = state_q != PH_IDLE;
        rdNext[`SEG_STAT_VALID] = validFlag_q;
        rdNext[`SEG_STAT_PHASE +: 2] = state_q;
      end
      `SEG_OFS_RESULT: rdNext = 32'(result);
      `SEG_OFS_STEP:   rdNext = 32'(stepSize);
      `SEG_OFS_SHIFT:  rdNext = 32'(shiftTotal);
      default:         rdOk = 1'b0;
    endcase
  end

  // read channel, one outstanding read
  assign arready = !rvalid;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rdNext;
      rresp <= rdOk ? 2'b00 : 2'b10;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // checks
  sequence s_coarse_end;
    state_q == PH_COARSE && coarseCnt_q == '0;
  endsequence

  sequence s_fine_two;
    state_q == PH_FINE [*3] ##1 state_q == PH_WAIT;
  endsequence

  a_offset_stable: assert property (@(posedge sys_clk) disable iff (rst) // R01
    state_q != PH_IDLE && !cycleStart |=> $stable(coarseOffsetShift))
    else $error("offset shift changed inside a measurement");

  a_step_row: assert property (@(posedge sys_clk) disable iff (rst) // R02
    cur_q.gainRow == 4'd13 |-> stepSize == 16'd83)
    else $error("wrong step for last gain row");

  a_res13_width: assert property (@(posedge sys_clk) disable iff (rst) // R04
    resultValid && !cur_q.res14 |-> result[13] == 1'b0)
    else $error("13 bit result uses bit 13");

  a_coarse_window: assert property (@(posedge sys_clk) disable iff (rst) // R06
    cycleStart |=> coarseIntegrate && coarseCnt_q == perCnt_q - 20'(curLay_q.fineBits) - 20'h3)
    else $error("coarse window not sized to cycle");

  a_fine_follows: assert property (@(posedge sys_clk) disable iff (rst) // R07
    s_coarse_end and cur_q.twoStep |=> state_q == PH_FINE && !coarseIntegrate)
    else $error("fine step did not follow coarse");

  a_one_step_skip: assert property (@(posedge sys_clk) disable iff (rst) // R08
    s_coarse_end and !cur_q.twoStep |=> resultValid && state_q == PH_WAIT)
    else $error("single segment did not finish at coarse end");

  a_fine_len: assert property (@(posedge sys_clk) disable iff (rst) // R09
    s_coarse_end and cur_q.twoStep && curLay_q.fineBits == 3'h2 |=> s_fine_two)
    else $error("fine step length wrong for split 00");

  a_period_end: assert property (@(posedge sys_clk) disable iff (rst) // R10
    state_q == PH_WAIT && perCnt_q == 20'h1 && cfg.run |=> cycleStart)
    else $error("measurement cycle did not restart on time");

  a_valid_after: assert property (@(posedge sys_clk) disable iff (rst) // R11
    resultValid && cur_q.twoStep |-> $past(state_q) == PH_FINE && state_q == PH_WAIT)
    else $error("result valid before fine step ended");

  a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (rst)
    bvalid && !bready |=> bvalid)
    else $error("write response dropped early");

endmodule

/* seg_adc_defs.svh */
`ifndef SEG_ADC_DEFS_SVH
`define SEG_ADC_DEFS_SVH

// register byte offsets
`define SEG_OFS_CTRL      8'h00
`define SEG_OFS_STATUS    8'h04
`define SEG_OFS_RESULT    8'h08
`define SEG_OFS_STEP      8'h0c
`define SEG_OFS_SHIFT     8'h10

// control field positions
`define SEG_CTRL_RUN      0
`define SEG_CTRL_RES14    1
`define SEG_CTRL_TWO      2
`define SEG_CTRL_SPLIT    3
`define SEG_CTRL_GAIN     8
`define SEG_CTRL_OFFSET   16

// status field positions
`define SEG_STAT_BUSY     0
`define SEG_STAT_VALID    1
`define SEG_STAT_PHASE    2

// reset values: stopped, 14 bit, two segment, split 00, gain row 1, no offset
`define SEG_CTRL_RST      32'h0000_0106

// clock rate and measurement cycle times in microseconds
`define SEG_CLK_MHZ       20
`define SEG_T14_00_US     19900
`define SEG_T14_01_US     10800
`define SEG_T14_10_US     6300
`define SEG_T14_11_US     4000
`define SEG_T13_00_US     10800
`define SEG_T13_01_US     6300
`define SEG_T13_10_US     4000
`define SEG_T13_11_US     2800
`define SEG_T14_ONE_US    37500
`define SEG_T13_ONE_US    19300

// offset shift per step in hundredths of a percent of full span
`define SEG_STEP_A        16'd1250
`define SEG_STEP_B        16'd760
`define SEG_STEP_C        16'd520
`define SEG_STEP_D        16'd83

`endif

/* seg_adc_pkg.sv */
package seg_adc_pkg;

  // live conversion settings as written by software
  typedef struct packed {
    logic [5:0] offsetCode;
    logic [3:0] gainRow;
    logic [1:0] split;
    logic       twoStep;
    logic       res14;
    logic       run;
  } cfg_s;

  // derived segment layout for one measurement
  typedef struct packed {
    logic [3:0]  coarseBits;
    logic [2:0]  fineBits;
    logic [19:0] period;
  } layout_s;

  typedef enum logic [1:0] {PH_IDLE, PH_COARSE, PH_FINE, PH_WAIT} phase_e;

  typedef logic [19:0] count_t;

endpackage

/* seg_split_decode.sv */
`timescale 1ns/10ps
module seg_split_decode
  import seg_adc_pkg::*;
#(
  parameter int unsigned PER_CYC [10] = '{default: 1000}
)
(
  input  wire logic    res14,
  input  wire logic    twoStep,
  input  wire logic [1:0] split,
  output layout_s      layout
);

  logic [3:0] idx;

  // split code picks coarse/fine widths and the cycle time
  always_comb
  begin
    idx = 4'h0;
    layout = '0;
    if (twoStep)
    begin
      layout.fineBits = 3'(split) + 3'h2;
      layout.coarseBits = (res14 ? 4'hc : 4'hb) - 4'(split);
      idx = (res14 ? 4'h0 : 4'h4) + 4'(split);
    end
    else
    begin
      layout.fineBits = 3'h0;
      layout.coarseBits = res14 ? 4'he : 4'hd;
      idx = res14 ? 4'h8 : 4'h9;
    end
    layout.period = 20'(PER_CYC[idx]);
  end

endmodule

/* seg_fine_sar.sv */
`timescale 1ns/10ps
module seg_fine_sar
#(
  parameter int W = 5
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [2:0]   nBits,
  input  wire logic         cmpHigh,
  output logic [W-1:0]      dacCode,
  output logic              done
);

  logic [2:0] bitIdx_q;
  logic       active_q;

  // one trial bit per cycle, kept while the residual stays above the trial level
  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      dacCode <= '0;
      bitIdx_q <= 3'h0;
      active_q <= 1'b0;
    end
    else if (start)
    begin
      dacCode <= W'(1) << (nBits - 3'h1);
      bitIdx_q <= nBits - 3'h1;
      active_q <= 1'b1;
    end
    else if (active_q)
    begin
      if (!cmpHigh)
        dacCode[bitIdx_q] <= 1'b0;
      if (bitIdx_q == 3'h0)
      begin
        active_q <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        dacCode[bitIdx_q - 3'h1] <= 1'b1;
        bitIdx_q <= bitIdx_q - 3'h1;
      end
    end
  end

endmodule

/* seg_bridge_model.sv */
`timescale 1ns/10ps
module seg_bridge_model
(
  input  wire logic [13:0] level,
  input  wire logic        fineHigh,
  input  wire logic        coarseIntegrate,
  input  wire logic [4:0]  fineDac,
  output logic      [13:0] coarseCode,
  output logic             fineCompare
);
  // coarse code valid only while integrating, inverse pattern otherwise
  assign coarseCode = coarseIntegrate ? level : ~level;
  // residual sits above every trial level or below all of them
  assign fineCompare = ({1'b0, fineDac} < (fineHigh ? 6'h20 : 6'h00));
endmodule

/* tb_segmented_adc_sequencer.sv */
`timescale 1ns/10ps
`include "seg_adc_defs.svh"
`define CHK(nm, ex, ac) begin checked++; if ((ex) !== (ac)) begin mismatch(nm, ex, ac); end end
module tb_segmented_adc_sequencer
  import seg_adc_pkg::*;
;
  localparam int unsigned PER [10] = '{200, 210, 220, 230, 240, 250, 260, 270, 300, 280};
  logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, coarseIntegrate, fineCompare;
  logic        resultValid, fineHigh, two, r14;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, ctrl;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, sp;
  logic [5:0]  coarseOffsetShift, off;
  logic [13:0] coarseCode, result, res, level, expRes;
  logic [4:0]  fineDac;
  int          badCount, checked, n, nf, nc, gain, intLen, lastInt;

  segmented_adc_sequencer #(.PER_CYC(PER)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .coarseOffsetShift(coarseOffsetShift),
    .coarseIntegrate(coarseIntegrate), .coarseCode(coarseCode), .fineDac(fineDac),
    .fineCompare(fineCompare), .result(result), .resultValid(resultValid));

  seg_bridge_model bridge_u (.level(level), .fineHigh(fineHigh),
    .coarseIntegrate(coarseIntegrate), .fineDac(fineDac), .coarseCode(coarseCode),
    .fineCompare(fineCompare));

  // clock at 20 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // length of the last finished coarse window
  always @(negedge sys_clk)
  begin
    if (coarseIntegrate === 1'b1)
      intLen++;
    else if (intLen != 0)
    begin
      lastInt = intLen;
      intLen = 0;
    end
  end

  task automatic mismatch(input string nm, input logic [31:0] ex, input logic [31:0] ac);
    $display("[ERR] %s expected %h seen %h", nm, ex, ac);
    badCount++;
  endtask

  task automatic conclude();
    if (badCount == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one write, address and data offered together
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge sys_clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    while (b !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar, rv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ar = arvalid && arready;
      rv = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge sys_clk);
      if (ar)
        arvalid <= 1'b0;
    end
    while (rv !== 1'b1);
    rready <= 1'b0;
    // one edge with rready low before the next read raises it again
    @(posedge sys_clk);
  endtask

  // cycles up to the next result pulse
  task automatic waitValid(output int c);
    c = 0;
    do
    begin
      @(negedge sys_clk);
      c++;
    end
    while (resultValid !== 1'b1 && c < 2000);
    res = result;
    @(posedge sys_clk);
  endtask

  function automatic logic [15:0] stepOf(input int row);
    case (row)
      2, 4, 6, 8, 11: stepOf = 16'h02f8;
      9, 12: stepOf = 16'h0208;
      13: stepOf = 16'h0053;
      default: stepOf = 16'h04e2;
    endcase
  endfunction

  // watchdog
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    badCount++;
    conclude();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, fineHigh} = 6'h00;
    {awaddr, araddr, wdata, wstrb, level} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    axiRead(`SEG_OFS_CTRL, d, r);
    `CHK("ctrl reset", 32'h0000_0106, d)
    for (int i = 0; i < 10; i++)
    begin
      two = (i < 8);
      r14 = (i < 4) || (i == 8);
      sp = 2'(i);
      nf = two ? int'(sp) + 2 : 0;
      nc = (r14 ? 14 : 13) - nf;
      gain = 4 + i;
      off = 6'h30 | 6'(i);
      level <= 14'h2a5c ^ 14'(i * 273);
      fineHigh <= i[0];
      expRes = ((14'h2a5c ^ 14'(i * 273)) & 14'((1 << nc) - 1)) << nf;
      expRes = expRes | 14'(i[0] ? (1 << nf) - 1 : 0);
      ctrl = {10'h000, off, 4'h0, 4'(gain), 3'h0, sp, two, r14, 1'b1};
      axiWrite(`SEG_OFS_CTRL, ctrl, r);
      waitValid(n);
      waitValid(n);
      waitValid(n);
      `CHK("period", PER[i], n)
      `CHK("result", expRes, res)
      `CHK("coarse window", PER[i] - nf - 3, lastInt)
      `CHK("offset pin", off, coarseOffsetShift)
      axiRead(`SEG_OFS_STEP, d, r);
      `CHK("step", {16'h0000, stepOf(gain)}, d)
      axiRead(`SEG_OFS_SHIFT, d, r);
      `CHK("shift", stepOf(gain) * off, d)
      axiRead(`SEG_OFS_RESULT, d, r);
      `CHK("result reg", {18'h00000, expRes}, d)
    end
    axiWrite(`SEG_OFS_RESULT, 32'h0000_0001, r);
    `CHK("ro write resp", 2'b10, r)
    axiRead(8'h20, d, r);
    `CHK("unmapped resp", 2'b10, r)
    `CHK("unmapped data", 32'h0000_0000, d)
    axiWrite(`SEG_OFS_CTRL, ctrl & 32'hffff_fffe, r);
    repeat (400) @(posedge sys_clk);
    axiRead(`SEG_OFS_STATUS, d, r);
    `CHK("status valid", 2'b10, d[1:0])
    axiWrite(`SEG_OFS_STATUS, 32'h0000_0002, r);
    axiRead(`SEG_OFS_STATUS, d, r);
    `CHK("status cleared", 2'b00, d[1:0])
    conclude();
  end
endmodule
